// >>> sas_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: Included by its bare name; definitions only.
// Notes: Timing counts are in converter clocks or in half converter clocks, the halves so that .5 points land on an edge.
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define SAS_OFF_CHREF 8'h00
`define SAS_OFF_CSA 8'h04
`define SAS_OFF_CSB 8'h08
`define SAS_OFF_RES_LO 8'h0C
`define SAS_OFF_RES_HI 8'h10
`define SAS_OFF_DIDR 8'h14
`define SAS_OFF_PWR 8'h18
`define SAS_OFF_PINS 8'h1C

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define SAS_CHREF_REF_LSB 6
`define SAS_CHREF_LADJ 5
`define SAS_CHREF_CHAN_LSB 0
`define SAS_CSA_EN 7
`define SAS_CSA_SC 6
`define SAS_CSA_ATE 5
`define SAS_CSA_FLAG 4
`define SAS_CSA_PS_LSB 0
`define SAS_CSB_COMPARATOR_MUX_ENABLE 6
`define SAS_CSB_TS_LSB 0
`define SAS_PWR_PR 0

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define SAS_RST_BYTE 8'h00
`define SAS_RST_DIDR 2'h0

// -----------------------------------------------------------------
// Timing in converter clocks and in half converter clocks
// -----------------------------------------------------------------
`define SAS_NORM_LEN_CC 13
`define SAS_FIRST_LEN_CC 25
`define SAS_NORM_SH_X2 3
`define SAS_FIRST_SH_X2 27
`define SAS_AUTO_SH_CC 2
`define SAS_AUTO_LEN_X2 27
`define SAS_NORM_LEN_HC (2 * `SAS_NORM_LEN_CC)
`define SAS_FIRST_LEN_HC (2 * `SAS_FIRST_LEN_CC)
`define SAS_AUTO_SH_HC (2 * `SAS_AUTO_SH_CC)
`define SAS_SYNC_STAGES 3

`endif

// >>> sas_pkg.sv
// Purpose: Types shared by the converter sequencer.
// Assumes: Nothing beyond the map header.
// Notes: All state of the sequencer lives in one packed struct.
`default_nettype none
package sas_pkg;

  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {SAS_ST_IDLE, SAS_ST_WAIT, SAS_ST_CONV} sas_state_t;
  typedef enum logic [1:0] {SAS_MD_NORM, SAS_MD_FIRST, SAS_MD_AUTO} sas_mode_t;

  typedef struct packed {
    logic [1:0] ref_sel;
    logic ladj;
    logic [2:0] chan;
    logic cen;
    logic ate;
    logic flag;
    logic [2:0] ps;
    logic comparator_mux_enable;
    logic [2:0] ts;
    logic pr;
    logic [1:0] didr;
    logic [9:0] res;
    logic lock;
    logic [2:0] chan_act;
    logic [1:0] ref_act;
    logic [7:0] presc;
    sas_state_t st;
    sas_mode_t mode;
    logic [5:0] hc;
    logic first;
    logic [2:0] tsync;
    logic tprev;
    logic sample;
    logic done;
    logic [1:0] pin_rd;
    logic [31:0] prdata;
    logic err;
  } sas_regs_t;

endpackage
`default_nettype wire

// >>> sas_sequencer.sv
// Purpose: Control logic of a 10-bit successive approximation converter with APB registers.
// Assumes: Inputs synchronous to mclk, except the trigger lines, which are resynchronised.
// Notes: The converter clock is a tick derived from mclk, not a separate clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "sas_map.svh"

// How it works
// - Comparator negative input from mux when converter disabled.
// - Disabled comparator pin buffer reads as zero.
// - Ten-bit result split, right or left aligned.
// - Selections reach converter only while enabled.
// - Low byte read locks results until high.
// - Completion flag sets even when result dropped.
// - Start bit begins conversion, clears at end unless free running.
// - Channel change waits for current conversion.
// - Trigger rising edge resets prescaler, starts conversion.
// - Edges during conversion and held levels ignored.
// - Completion flag as source means free running.
// - Start bit works under auto trigger too.
// - Prescaler held reset while converter disabled.
// - Requested conversion starts at next converter edge.
// - Thirteen clocks normally, twenty-five first time.
// - Sample at 1.5 or 13.5 converter clocks.
// - Completion writes result unless locked, sets flag, clears start unless free running.
// - Auto trigger: sample at 2, last 13.5.
// - Differential auto trigger conversions take twenty-five.
// - Selections follow writes except while converting, up to the last two half clocks.
module sas_sequencer #(
  parameter int ADDR_W = 8,
  parameter logic [2:0] TRIG_SRC_COMPLETE = 3'h0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger sources and mode strap
  input wire logic [7:0] trig_src,
  input wire logic diff_mode,
  // Analog core
  input wire logic [9:0] core_result,
  output logic core_enable,
  output logic [2:0] core_chan_sel,
  output logic [1:0] core_ref_sel,
  output logic core_converting,
  output logic core_sample,
  output logic conv_done,
  // Analog comparator
  output logic comp_neg_from_mux,
  output logic [2:0] comp_neg_chan,
  input wire logic [1:0] comp_pin_raw,
  output logic [1:0] comp_pin_buf_en,
  output logic [1:0] comp_pin_read
);
  import sas_pkg::*;

  // -----------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------
  if (ADDR_W < 5 || ADDR_W > 8)
  begin : g_chk
    $error("ADDR_W must lie between 5 and 8");
  end

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] res_byte(input logic [9:0] r, input logic ladj,
                                          input logic high);
    logic [7:0] b;
    b = 8'h00;
    if (ladj)
    begin
      b = high ? r[9:2] : {r[1:0], 6'h00};
    end
    else
    begin
      b = high ? {6'h00, r[9:8]} : r[7:0];
    end
    return b;
  endfunction

  function automatic logic [5:0] len_of(input sas_mode_t m);
    logic [5:0] l;
    l = 6'(`SAS_NORM_LEN_HC);
    case (m)
      SAS_MD_FIRST: l = 6'(`SAS_FIRST_LEN_HC);
      SAS_MD_AUTO: l = 6'(`SAS_AUTO_LEN_X2);
      default: l = 6'(`SAS_NORM_LEN_HC);
    endcase
    return l;
  endfunction

  function automatic logic [5:0] sh_of(input sas_mode_t m);
    logic [5:0] s;
    s = 6'(`SAS_NORM_SH_X2);
    case (m)
      SAS_MD_FIRST: s = 6'(`SAS_FIRST_SH_X2);
      SAS_MD_AUTO: s = 6'(`SAS_AUTO_SH_HC);
      default: s = 6'(`SAS_NORM_SH_X2);
    endcase
    return s;
  endfunction

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  sas_regs_t q;
  sas_regs_t d;
  logic [7:0] addr8;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic en;
  logic [7:0] ratio_m1;
  logic [7:0] half_m1;
  logic tick_full;
  logic tick_half;
  logic ev;
  logic trig_edge;
  logic free_run;
  logic [5:0] hc_nx;
  logic [31:0] rword;
  logic hit;

  always_comb
  begin
    d = q;
    addr8 = 8'(paddr);
    setup = psel & ~penable;
    access = psel & penable;
    wr = access & pwrite;
    rd = access & ~pwrite;
    // Power reduction must be cleared before the enable takes hold.
    en = q.cen & ~q.pr;
    // Division ratio is two shifted left by the select code.
    ratio_m1 = 8'((9'h002 << q.ps) - 9'h001);
    half_m1 = 8'((9'h001 << q.ps) - 9'h001);
    tick_full = en & (q.presc == ratio_m1);
    tick_half = en & (q.presc == half_m1);
    ev = tick_full | tick_half;
    trig_edge = q.tsync[2] & ~q.tprev;
    free_run = q.ate & (q.ts == TRIG_SRC_COMPLETE);
    hc_nx = q.hc + 6'h01;
    rword = 32'h0000_0000;
    hit = 1'b1;
    d.sample = 1'b0;
    d.done = 1'b0;

    // ---------------------------------------------------------------
    // Register read data, captured in the setup cycle
    // ---------------------------------------------------------------
    case (addr8)
      `SAS_OFF_CHREF: rword = {24'h0, q.ref_sel, q.ladj, 2'h0, q.chan};
      `SAS_OFF_CSA: rword = {24'h0, q.cen, q.st != SAS_ST_IDLE, q.ate, q.flag, 1'b0, q.ps};
      `SAS_OFF_CSB: rword = {24'h0, 1'b0, q.comparator_mux_enable, 3'h0, q.ts};
      `SAS_OFF_RES_LO: rword = {24'h0, res_byte(q.res, q.ladj, 1'b0)};
      `SAS_OFF_RES_HI: rword = {24'h0, res_byte(q.res, q.ladj, 1'b1)};
      `SAS_OFF_DIDR: rword = {30'h0, q.didr};
      `SAS_OFF_PWR: rword = {31'h0, q.pr};
      `SAS_OFF_PINS: rword = {30'h0, q.pin_rd};
      default:
      begin
        rword = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    if (setup)
    begin
      d.prdata = pwrite ? 32'h0000_0000 : rword;
      d.err = ~hit;
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    if (wr)
    begin
      case (addr8)
        `SAS_OFF_CHREF:
        begin
          d.ref_sel = pwdata[`SAS_CHREF_REF_LSB +: 2];
          d.ladj = pwdata[`SAS_CHREF_LADJ];
          d.chan = pwdata[`SAS_CHREF_CHAN_LSB +: 3];
        end
        `SAS_OFF_CSA:
        begin
          d.cen = pwdata[`SAS_CSA_EN];
          d.ate = pwdata[`SAS_CSA_ATE];
          d.ps = pwdata[`SAS_CSA_PS_LSB +: 3];
          if (pwdata[`SAS_CSA_FLAG])
          begin
            d.flag = 1'b0;
          end
          // Writing one asks for a conversion at the next converter edge.
          if (pwdata[`SAS_CSA_SC] && en && q.st == SAS_ST_IDLE)
          begin
            d.st = SAS_ST_WAIT;
          end
        end
        `SAS_OFF_CSB:
        begin
          d.comparator_mux_enable = pwdata[`SAS_CSB_COMPARATOR_MUX_ENABLE];
          d.ts = pwdata[`SAS_CSB_TS_LSB +: 3];
        end
        `SAS_OFF_DIDR: d.didr = pwdata[1:0];
        `SAS_OFF_PWR: d.pr = pwdata[`SAS_PWR_PR];
        default: d.err = q.err;
      endcase
    end

    // ---------------------------------------------------------------
    // Result lock, set by a low byte read, released by a high byte read
    // ---------------------------------------------------------------
    // The lock is taken at the capture edge, so no later result can split the pair.
    if (setup && !pwrite && addr8 == `SAS_OFF_RES_LO)
    begin
      d.lock = 1'b1;
    end
    if (rd && addr8 == `SAS_OFF_RES_HI)
    begin
      d.lock = 1'b0;
    end

    // ---------------------------------------------------------------
    // Prescaler
    // ---------------------------------------------------------------
    if (!en)
    begin
      d.presc = 8'h00;
    end
    else if (tick_full)
    begin
      d.presc = 8'h00;
    end
    else
    begin
      d.presc = q.presc + 8'h01;
    end

    // ---------------------------------------------------------------
    // Trigger synchroniser; the three stages are the CPU clock delay.
    // ---------------------------------------------------------------
    d.tsync = {q.tsync[1:0], trig_src[q.ts]};
    d.tprev = q.tsync[2];

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    case (q.st)
      SAS_ST_IDLE:
      begin
        // Only an idle sequencer sees edges, and only edges, not levels.
        if (en && q.ate && !free_run && trig_edge)
        begin
          d.presc = 8'h00;
          d.st = SAS_ST_CONV;
          d.hc = 6'h00;
          // Differential auto conversions restart the analog side each time.
          d.mode = (q.first || diff_mode) ? SAS_MD_FIRST : SAS_MD_AUTO;
        end
      end
      SAS_ST_WAIT:
      begin
        if (tick_full)
        begin
          d.st = SAS_ST_CONV;
          d.hc = 6'h00;
          d.mode = q.first ? SAS_MD_FIRST : SAS_MD_NORM;
        end
      end
      SAS_ST_CONV:
      begin
        if (ev)
        begin
          d.hc = hc_nx;
          if (hc_nx == sh_of(q.mode))
          begin
            d.sample = 1'b1;
          end
          if (hc_nx == len_of(q.mode))
          begin
            d.done = 1'b1;
            d.first = 1'b0;
            d.flag = 1'b1;
            if (!q.lock)
            begin
              d.res = core_result;
            end
            if (free_run)
            begin
              d.hc = 6'h00;
              d.mode = SAS_MD_NORM;
            end
            else
            begin
              d.st = SAS_ST_IDLE;
            end
          end
        end
      end
      default: d.st = SAS_ST_IDLE;
    endcase

    // Leaving the enable off aborts work and arms the long first conversion.
    if (!en)
    begin
      d.st = SAS_ST_IDLE;
      d.first = 1'b1;
      d.hc = 6'h00;
    end

    // A result landing on the capture edge of a low byte read is the one returned.
    if (setup && !pwrite && addr8 == `SAS_OFF_RES_LO)
    begin
      d.prdata = {24'h0, res_byte(d.res, q.ladj, 1'b0)};
    end

    // ---------------------------------------------------------------
    // Selection copy: frozen during conversion until the last two half clocks, so the sample stays valid.
    // ---------------------------------------------------------------
    if (q.st != SAS_ST_CONV || (q.hc + 6'h02) >= len_of(q.mode))
    begin
      d.chan_act = q.chan;
      d.ref_act = q.ref_sel;
    end

    // Digital pin read path, forced low while the buffer is off.
    d.pin_rd = comp_pin_raw & ~q.didr;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & q.err;
  assign core_enable = en;
  assign core_chan_sel = en ? q.chan_act : 3'h0;
  assign core_ref_sel = en ? q.ref_act : 2'h0;
  assign core_converting = q.st == SAS_ST_CONV;
  assign core_sample = q.sample;
  assign conv_done = q.done;
  assign comp_neg_from_mux = q.comparator_mux_enable & ~en;
  assign comp_neg_chan = q.chan;
  assign comp_pin_buf_en = ~q.didr;
  assign comp_pin_read = q.pin_rd;

endmodule
`default_nettype wire

// >>> sas_sequencer_props.sv
// Purpose: Port-level checks of the converter sequencer.
// Assumes: Bound to sas_sequencer and sees only its ports.
// Notes: Register fields are judged through the outputs that they drive.
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Converter and comparator outputs, and the raw comparator pins
  input wire logic core_enable,
  input wire logic [2:0] core_chan_sel,
  input wire logic [1:0] core_ref_sel,
  input wire logic core_converting,
  input wire logic core_sample,
  input wire logic conv_done,
  input wire logic comp_neg_from_mux,
  input wire logic [1:0] comp_pin_raw,
  input wire logic [1:0] comp_pin_buf_en,
  input wire logic [1:0] comp_pin_read
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_start;
    $rose(core_converting);
  endsequence
  sequence s_sel_held;
    ($stable(core_chan_sel) && $stable(core_ref_sel)) [*8];
  endsequence
  // Remembers a sample point since the last completion; there is no fixed wait, so any prescaler setting is covered.
  logic seen_q;
  always_ff @(posedge mclk)
  begin
    if (!rst_b || !core_enable || conv_done)
    begin
      seen_q <= 1'b0;
    end
    else if (core_sample)
    begin
      seen_q <= 1'b1;
    end
  end
  a_mux_route: assert property (comp_neg_from_mux |-> !core_enable)
    else $error("comparator mux taken while converter enabled");
  a_pin_zero: assert property ($past(rst_b) |->
    comp_pin_read == ($past(comp_pin_raw) & $past(comp_pin_buf_en)))
    else $error("disabled comparator pin not reading zero");
  a_sel_gated: assert property (!core_enable [*2] |-> core_chan_sel == 3'h0 && core_ref_sel == 2'h0)
    else $error("selection reaches converter while disabled");
  a_chan_frozen: assert property (s_start |=> s_sel_held)
    else $error("selection moved early in a conversion");
  a_stop_off: assert property (!core_enable [*2] |-> !core_converting)
    else $error("converting while disabled");
  a_run_min: assert property (s_start |=> core_converting [*8])
    else $error("conversion ended too soon");
  a_sample_due: assert property (conv_done |-> seen_q)
    else $error("conversion completed without a sample point");
  a_sample_pulse: assert property (core_sample |-> core_converting ##1 !core_sample)
    else $error("sample pulse outside conversion or too long");
  a_done_pulse: assert property (conv_done |-> ($past(core_converting) || $past(core_converting, 2)) ##1 !conv_done)
    else $error("completion pulse without conversion");
endmodule
bind sas_sequencer sas_sequencer_props props_u (.mclk(mclk), .rst_b(rst_b),
  .core_enable(core_enable), .core_chan_sel(core_chan_sel), .core_ref_sel(core_ref_sel),
  .core_converting(core_converting), .core_sample(core_sample), .conv_done(conv_done),
  .comp_neg_from_mux(comp_neg_from_mux), .comp_pin_raw(comp_pin_raw),
  .comp_pin_buf_en(comp_pin_buf_en), .comp_pin_read(comp_pin_read));
`default_nettype wire

// >>> sas_core_model.sv
// Purpose: Behavioural analog core that answers the sequencer.
// Assumes: The result is held from the sample pulse to the end of conversion.
// Notes: Outside a conversion the lines churn, so a stale capture shows.
`timescale 1ns/1ps
`default_nettype none
module sas_core_model (
  // Clock
  input wire logic mclk,
  // Converter side
  input wire logic core_enable,
  input wire logic [2:0] core_chan_sel,
  input wire logic [1:0] core_ref_sel,
  input wire logic core_converting,
  input wire logic core_sample,
  output logic [9:0] core_result
);
  logic [9:0] held = 10'h000;
  logic [9:0] churn = 10'h155;
  always @(posedge mclk)
  begin
    churn <= ~churn + 10'h0B7;
    if (core_sample && core_enable)
      held <= 10'h2A5 ^ {core_ref_sel, 5'h00, core_chan_sel};
  end
  assign core_result = core_converting ? held : churn;
endmodule
`default_nettype wire

// >>> test_sas_sequencer.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Core model in sas_core_model; checks bound from the props file.
// Notes: Expected values come from the bench model, never from the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module test_sas_sequencer;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, diff_mode, err_q;
  logic core_enable, core_converting, core_sample, conv_done, comp_neg_from_mux;
  logic [7:0] paddr, trig_src;
  logic [31:0] pwdata, prdata, rd_q;
  logic [9:0] core_result, e;
  logic [2:0] core_chan_sel, comp_neg_chan, c;
  logic [1:0] core_ref_sel, comp_pin_raw, comp_pin_buf_en, comp_pin_read, r, dd;
  int fail_count, samples_checked, cyc, done_cnt, done_at, k, t0;
  logic [9:0] exp_q[$];
  // Bench model of the core's answer from the selections held at the sample point.
  function automatic logic [9:0] exp_res(input logic [1:0] rf, input logic [2:0] ch);
    return 10'h2A5 ^ {rf, 5'h00, ch};
  endfunction
  sas_sequencer #(.ADDR_W(8), .TRIG_SRC_COMPLETE(3'h0)) dut_u (.mclk(mclk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_src(trig_src),
    .diff_mode(diff_mode), .core_result(core_result), .core_enable(core_enable),
    .core_chan_sel(core_chan_sel), .core_ref_sel(core_ref_sel), .conv_done(conv_done),
    .core_converting(core_converting), .core_sample(core_sample),
    .comp_neg_from_mux(comp_neg_from_mux), .comp_neg_chan(comp_neg_chan),
    .comp_pin_raw(comp_pin_raw), .comp_pin_buf_en(comp_pin_buf_en),
    .comp_pin_read(comp_pin_read));
  sas_core_model core_u (.mclk(mclk), .core_enable(core_enable),
    .core_chan_sel(core_chan_sel), .core_ref_sel(core_ref_sel),
    .core_converting(core_converting), .core_sample(core_sample),
    .core_result(core_result));
  always #25 mclk = ~mclk;
  // ------------------------------------------------------------
  // Cycle count, completion log and hang limit
  // ------------------------------------------------------------
  // Counting on the falling edge keeps the registered pulse clear of its launching edge.
  always @(negedge mclk)
  begin
    cyc++;
    if (conv_done === 1'b1)
    begin
      done_cnt++;
      done_at = cyc;
    end
    if (cyc == 20000)
    begin
      fail_count++;
      results();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(nm, x, rd_q)
  endtask
  // The start edge is taken from t0, set by the caller, so a read between start and end does not skew the count.
  task automatic wait_done(input int cc, input int ratio);
    int c0;
    c0 = done_cnt;
    while (done_cnt == c0 && cyc < t0 + 3000)
      @(posedge mclk);
    `CHK("length", 1'b1, done_at - t0 >= cc * ratio && done_at - t0 <= cc * ratio + ratio + 4)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    {mclk, rst_b, psel, penable, pwrite, paddr, pwdata, trig_src, diff_mode} = '0;
    comp_pin_raw = 2'h0;
    void'($urandom(32'h6254));
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    rdc("didr reset", 8'h14, 32'h0);
    apb(1'b1, 8'h14, 32'hFF);
    rdc("didr bits", 8'h14, 32'h3);
    dd = 2'($urandom);
    comp_pin_raw <= 2'($urandom);
    apb(1'b1, 8'h14, {30'h0, dd});
    rdc("pins", 8'h1C, {30'h0, comp_pin_raw & ~dd});
    `CHK("buffer enable", ~dd, comp_pin_buf_en)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped error", 1'b1, err_q)
    $display("test registers done");
    apb(1'b1, 8'h08, 32'h40);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, 8'h00, i);
      @(posedge mclk);
      `CHK("mux on", 1'b1, comp_neg_from_mux)
      `CHK("mux channel", 3'(i), comp_neg_chan)
      `CHK("gated channel", 3'h0, core_chan_sel)
    end
    c = 3'($urandom);
    r = 2'($urandom);
    apb(1'b1, 8'h00, {24'h0, r, 3'h0, c});
    apb(1'b1, 8'h18, 32'h1);
    apb(1'b1, 8'h04, 32'h80);
    `CHK("power gate", 1'b0, core_enable)
    apb(1'b1, 8'h18, 32'h0);
    @(posedge mclk);
    `CHK("mux off", 1'b0, comp_neg_from_mux)
    `CHK("channel applied", c, core_chan_sel)
    $display("test routing done");
    exp_q.push_back(exp_res(r, c));
    apb(1'b1, 8'h04, 32'hC0);
    t0 = cyc;
    wait_done(25, 2);
    e = exp_q.pop_front();
    rdc("flag set start clear", 8'h04, 32'h90);
    rdc("right low", 8'h0C, {24'h0, e[7:0]});
    rdc("right high", 8'h10, {30'h0, e[9:8]});
    c = 3'($urandom);
    apb(1'b1, 8'h00, {24'h0, r, 3'h4, c});
    exp_q.push_back(exp_res(r, c));
    apb(1'b1, 8'h04, 32'hD1);
    t0 = cyc;
    rdc("start busy", 8'h04, 32'hC1);
    apb(1'b1, 8'h00, {24'h0, r, 3'h4, ~c});
    wait_done(13, 4);
    e = exp_q.pop_front();
    rdc("left low", 8'h0C, {24'h0, e[1:0], 6'h00});
    rdc("left high", 8'h10, {24'h0, e[9:2]});
    $display("test single done");
    rdc("lock low", 8'h0C, {24'h0, e[1:0], 6'h00});
    apb(1'b1, 8'h04, 32'hD6);
    t0 = cyc;
    wait_done(13, 128);
    rdc("flag while locked", 8'h04, 32'h96);
    rdc("kept high", 8'h10, {24'h0, e[9:2]});
    rdc("kept low", 8'h0C, {24'h0, e[1:0], 6'h00});
    rdc("kept high again", 8'h10, {24'h0, e[9:2]});
    $display("test lock done");
    apb(1'b1, 8'h08, 32'h01);
    apb(1'b1, 8'h04, 32'hB1);
    k = done_cnt;
    trig_src <= 8'h02;
    repeat (12) @(posedge mclk);
    trig_src <= 8'h00;
    repeat (2) @(posedge mclk);
    trig_src <= 8'h02;
    repeat (200) @(posedge mclk);
    `CHK("one trigger", 1, done_cnt - k)
    exp_q.push_back(exp_res(r, ~c));
    e = exp_q.pop_front();
    rdc("trig low", 8'h0C, {24'h0, e[1:0], 6'h00});
    rdc("trig high", 8'h10, {24'h0, e[9:2]});
    diff_mode <= 1'b1;
    trig_src <= 8'h00;
    repeat (6) @(posedge mclk);
    trig_src <= 8'h02;
    t0 = cyc;
    wait_done(25, 4);
    diff_mode <= 1'b0;
    k = done_cnt;
    apb(1'b1, 8'h04, 32'hF1);
    repeat (200) @(posedge mclk);
    `CHK("start under auto", 1, done_cnt - k)
    apb(1'b1, 8'h08, 32'h00);
    k = done_cnt;
    apb(1'b1, 8'h04, 32'hF1);
    repeat (300) @(posedge mclk);
    `CHK("free run", 1'b1, done_cnt - k >= 4)
    apb(1'b0, 8'h04, 32'h0);
    `CHK("start held", 1'b1, rd_q[6])
    apb(1'b1, 8'h04, 32'h00);
    $display("test auto done");
    results();
  end
endmodule
`default_nettype wire
